// >>> common/spdma_map.svh
// register offsets, control bit positions and reset values of the serial dma
`ifndef SPDMA_MAP_SVH
`define SPDMA_MAP_SVH
`define SPDMA_AW 16
`define SPDMA_ADDR_W 14
`define SPDMA_ADDR_BASE 32'h2000_0000
`define SPDMA_ADDR_RST 14'h0000
`define SPDMA_REG_RST 32'h0000_0000
`define SPDMA_OFF_RX_BEG_A 16'hC800
`define SPDMA_OFF_RX_END_A 16'hC804
`define SPDMA_OFF_RX_BEG_B 16'hC808
`define SPDMA_OFF_RX_END_B 16'hC80C
`define SPDMA_OFF_TX_BEG_A 16'hC810
`define SPDMA_OFF_TX_END_A 16'hC814
`define SPDMA_OFF_TX_BEG_B 16'hC818
`define SPDMA_OFF_TX_END_B 16'hC81C
`define SPDMA_OFF_TX_CNT 16'hC828
`define SPDMA_OFF_STAT 16'hC82C
`define SPDMA_OFF_CTRL 16'hC830
`define SPDMA_OFF_SAVED 16'hC840
`define SPDMA_CTL_TX_RST 5
`define SPDMA_CTL_RX_RST 4
`define SPDMA_CTL_TX_LD_HI 3
`define SPDMA_CTL_TX_LD_LO 2
`define SPDMA_CTL_RX_LD_HI 1
`define SPDMA_CTL_RX_LD_LO 0
`define SPDMA_SSEL_NONE 3'h0
`define SPDMA_SSEL_ONCE 2'h1
`define SPDMA_SSEL_MULTI 2'h3
`endif

// >>> common/spdma_pkg.sv
// state types of the serial ping-pong dma engine
package spdma_pkg;
  typedef enum logic [1:0] {
    SPDMA_TX_IDLE = 2'h0,
    SPDMA_TX_FETCH = 2'h1,
    SPDMA_TX_PUSH = 2'h3
  } spdma_tx_state_type;
  typedef enum logic [1:0] {
    SPDMA_RX_IDLE = 2'h0,
    SPDMA_RX_WAIT = 2'h1,
    SPDMA_RX_STORE = 2'h3
  } spdma_rx_state_type;
endpackage

// >>> rtl/spdma_top.sv
// serial ping-pong dma channel with wishbone register slave
`timescale 1ns/100ps
`include "spdma_map.svh"
`default_nettype none
module spdma_top #(
  parameter bit FIRST_CONTROLLER = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic tx_mem_req_o,
  output logic [13:0] tx_mem_addr_o,
  input wire logic tx_mem_ack_i,
  input wire logic [7:0] tx_mem_data_i,
  output logic tx_fifo_valid_o,
  input wire logic tx_fifo_ready_i,
  output logic [7:0] tx_fifo_data_o,
  input wire logic rx_fifo_valid_i,
  output logic rx_fifo_ready_o,
  input wire logic [7:0] rx_fifo_data_i,
  input wire logic rx_fifo_frame_err_i,
  input wire logic rx_fifo_parity_err_i,
  input wire logic rx_fifo_overflow_i,
  input wire logic uart_mode_i,
  input wire logic spi_slave_mode_i,
  input wire logic slave_select_n_i,
  output logic rx_mem_req_o,
  output logic [13:0] rx_mem_addr_o,
  output logic [7:0] rx_mem_data_o,
  input wire logic rx_mem_ack_i
);
  import spdma_pkg::*;

  function automatic logic [1:0] one_hot(input logic s);
    one_hot = s ? 2'b10 : 2'b01;
  endfunction

  function automatic logic [13:0] merge_addr(input logic [13:0] old,
      input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge_addr = (old & ~m[13:0]) | (dat[13:0] & m[13:0]);
  endfunction

  // bus slave: one wait state, write commits on the acking edge
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rd_mux;
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire ack_next = bus_req & ~ack_reg;
  wire wr_cmt = bus_req & wb_we_i & ack_reg;
  wire wr_ctrl = wr_cmt & (wb_adr_i == `SPDMA_OFF_CTRL) & wb_sel_i[0];
  wire tx_rst = wr_ctrl & wb_dat_i[`SPDMA_CTL_TX_RST];
  wire rx_rst = wr_ctrl & wb_dat_i[`SPDMA_CTL_RX_RST];
  // reset wins over a load carried in the same write
  wire [1:0] tx_set = (wr_ctrl & ~tx_rst) ?
    wb_dat_i[`SPDMA_CTL_TX_LD_HI:`SPDMA_CTL_TX_LD_LO] : 2'b00;
  wire [1:0] rx_set = (wr_ctrl & ~rx_rst) ?
    wb_dat_i[`SPDMA_CTL_RX_LD_HI:`SPDMA_CTL_RX_LD_LO] : 2'b00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= `SPDMA_REG_RST;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= ack_next ? rd_mux : `SPDMA_REG_RST;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // per-buffer address registers and the copies latched at load
  logic [13:0] tx_lbeg [2];
  logic [13:0] tx_lend [2];
  logic [13:0] rx_lbeg [2];
  logic [13:0] rx_lend [2];
  for (genvar b = 0; b < 2; b++) begin : g_buf
    logic [13:0] tx_beg_reg;
    logic [13:0] tx_end_reg;
    logic [13:0] rx_beg_reg;
    logic [13:0] rx_end_reg;
    logic [13:0] tx_lbeg_reg;
    logic [13:0] tx_lend_reg;
    logic [13:0] rx_lbeg_reg;
    logic [13:0] rx_lend_reg;
    wire [15:0] off_tb = b ? `SPDMA_OFF_TX_BEG_B : `SPDMA_OFF_TX_BEG_A;
    wire [15:0] off_te = b ? `SPDMA_OFF_TX_END_B : `SPDMA_OFF_TX_END_A;
    wire [15:0] off_rb = b ? `SPDMA_OFF_RX_BEG_B : `SPDMA_OFF_RX_BEG_A;
    wire [15:0] off_re = b ? `SPDMA_OFF_RX_END_B : `SPDMA_OFF_RX_END_A;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tx_beg_reg <= `SPDMA_ADDR_RST;
        tx_end_reg <= `SPDMA_ADDR_RST;
        rx_beg_reg <= `SPDMA_ADDR_RST;
        rx_end_reg <= `SPDMA_ADDR_RST;
        tx_lbeg_reg <= `SPDMA_ADDR_RST;
        tx_lend_reg <= `SPDMA_ADDR_RST;
        rx_lbeg_reg <= `SPDMA_ADDR_RST;
        rx_lend_reg <= `SPDMA_ADDR_RST;
      end else begin
        if (wr_cmt && wb_adr_i == off_tb) begin
          tx_beg_reg <= merge_addr(tx_beg_reg, wb_dat_i, wb_sel_i);
        end
        if (wr_cmt && wb_adr_i == off_te) begin
          tx_end_reg <= merge_addr(tx_end_reg, wb_dat_i, wb_sel_i);
        end
        if (wr_cmt && wb_adr_i == off_rb) begin
          rx_beg_reg <= merge_addr(rx_beg_reg, wb_dat_i, wb_sel_i);
        end
        if (wr_cmt && wb_adr_i == off_re) begin
          rx_end_reg <= merge_addr(rx_end_reg, wb_dat_i, wb_sel_i);
        end
        if (tx_set[b]) begin
          tx_lbeg_reg <= tx_beg_reg;
          tx_lend_reg <= tx_end_reg;
        end
        if (rx_set[b]) begin
          rx_lbeg_reg <= rx_beg_reg;
          rx_lend_reg <= rx_end_reg;
        end
      end
    end
    assign tx_lbeg[b] = tx_lbeg_reg;
    assign tx_lend[b] = tx_lend_reg;
    assign rx_lbeg[b] = rx_lbeg_reg;
    assign rx_lend[b] = rx_lend_reg;
  end

  // transmit direction
  spdma_tx_state_type tx_state_reg;
  spdma_tx_state_type tx_state_next;
  logic tx_sel_reg;
  logic tx_sel_next;
  logic [13:0] tx_cnt_reg;
  logic [13:0] tx_cnt_next;
  logic [1:0] tx_load_reg;
  logic [7:0] tx_byte_reg;
  wire [13:0] tx_addr = tx_lbeg[tx_sel_reg] + tx_cnt_reg;
  wire tx_last = tx_addr == tx_lend[tx_sel_reg];
  wire tx_done = (tx_state_reg == SPDMA_TX_PUSH) & tx_fifo_ready_i & tx_last;
  wire [1:0] tx_clr = tx_done ? one_hot(tx_sel_reg) : 2'b00;
  // a new load wins over the completion clear of the same cycle
  wire [1:0] tx_load_next = tx_rst ? 2'b00 :
    (tx_set | (tx_load_reg & ~tx_clr));
  wire [1:0] tx_active = (tx_state_reg != SPDMA_TX_IDLE) ?
    one_hot(tx_sel_reg) : 2'b00;

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_sel_next = tx_sel_reg;
    tx_cnt_next = tx_cnt_reg;
    case (tx_state_reg)
      SPDMA_TX_IDLE: begin
        if (|tx_load_reg) begin
          tx_state_next = SPDMA_TX_FETCH;
          tx_sel_next = ~tx_load_reg[0];
          tx_cnt_next = 14'h0000;
        end
      end
      SPDMA_TX_FETCH: begin
        if (tx_mem_ack_i) begin
          tx_state_next = SPDMA_TX_PUSH;
        end
      end
      SPDMA_TX_PUSH: begin
        if (tx_fifo_ready_i && !tx_last) begin
          tx_cnt_next = tx_cnt_reg + 14'h0001;
          tx_state_next = SPDMA_TX_FETCH;
        end else if (tx_fifo_ready_i) begin
          tx_cnt_next = 14'h0000;
          // prefer the other buffer so ping-pong has no gap
          if (tx_load_next[~tx_sel_reg]) begin
            tx_sel_next = ~tx_sel_reg;
            tx_state_next = SPDMA_TX_FETCH;
          end else if (tx_load_next[tx_sel_reg]) begin
            tx_state_next = SPDMA_TX_FETCH;
          end else begin
            tx_state_next = SPDMA_TX_IDLE;
          end
        end
      end
      default: tx_state_next = SPDMA_TX_IDLE;
    endcase
    if (tx_rst) begin
      tx_state_next = SPDMA_TX_IDLE;
      tx_cnt_next = 14'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg <= SPDMA_TX_IDLE;
      tx_sel_reg <= 1'b0;
      tx_cnt_reg <= 14'h0000;
      tx_load_reg <= 2'b00;
      tx_byte_reg <= 8'h00;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_sel_reg <= tx_sel_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_load_reg <= tx_load_next;
      if (tx_state_reg == SPDMA_TX_FETCH && tx_mem_ack_i) begin
        tx_byte_reg <= tx_mem_data_i;
      end
    end
  end
  assign tx_mem_req_o = tx_state_reg == SPDMA_TX_FETCH;
  assign tx_mem_addr_o = tx_addr;
  assign tx_fifo_valid_o = tx_state_reg == SPDMA_TX_PUSH;
  assign tx_fifo_data_o = tx_byte_reg;

  // receive direction
  spdma_rx_state_type rx_state_reg;
  spdma_rx_state_type rx_state_next;
  logic rx_sel_reg;
  logic rx_sel_next;
  logic [13:0] rx_cnt_reg;
  logic [13:0] rx_cnt_next;
  logic [1:0] rx_load_reg;
  logic [7:0] rx_byte_reg;
  logic [1:0] frm_reg;
  logic [1:0] par_reg;
  logic [1:0] ovr_reg;
  logic ovr_pend_reg;
  wire [13:0] rx_addr = rx_lbeg[rx_sel_reg] + rx_cnt_reg;
  wire rx_last = rx_addr == rx_lend[rx_sel_reg];
  wire rx_take = (rx_state_reg == SPDMA_RX_WAIT) & rx_fifo_valid_i;
  wire rx_done = (rx_state_reg == SPDMA_RX_STORE) & rx_mem_ack_i & rx_last;
  wire [1:0] rx_clr = rx_done ? one_hot(rx_sel_reg) : 2'b00;
  wire [1:0] rx_load_next = rx_rst ? 2'b00 :
    (rx_set | (rx_load_reg & ~rx_clr));
  wire [1:0] rx_active = (rx_state_reg != SPDMA_RX_IDLE) ?
    one_hot(rx_sel_reg) : 2'b00;
  wire [1:0] rx_take_buf = rx_take ? one_hot(rx_sel_reg) : 2'b00;
  // frame and parity flags only carry meaning on the first controller in uart mode
  wire err_en = FIRST_CONTROLLER & uart_mode_i;
  wire [1:0] frm_next = rx_rst ? 2'b00 : ((frm_reg & ~rx_set) |
    (rx_take_buf & {2{rx_fifo_frame_err_i & err_en}}));
  wire [1:0] par_next = rx_rst ? 2'b00 : ((par_reg & ~rx_set) |
    (rx_take_buf & {2{rx_fifo_parity_err_i & err_en}}));
  wire [1:0] ovr_next = rx_rst ? 2'b00 : ((ovr_reg & ~rx_set) |
    (rx_take_buf & {2{ovr_pend_reg}}));
  // overflow with nothing loaded waits for the next draining buffer
  wire ovr_pend_next = ~rx_rst & ((rx_fifo_overflow_i & ~|rx_load_reg) |
    (ovr_pend_reg & ~rx_take));

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_sel_next = rx_sel_reg;
    rx_cnt_next = rx_cnt_reg;
    case (rx_state_reg)
      SPDMA_RX_IDLE: begin
        if (|rx_load_reg) begin
          rx_state_next = SPDMA_RX_WAIT;
          rx_sel_next = ~rx_load_reg[0];
          rx_cnt_next = 14'h0000;
        end
      end
      SPDMA_RX_WAIT: begin
        if (rx_fifo_valid_i) begin
          rx_state_next = SPDMA_RX_STORE;
        end
      end
      SPDMA_RX_STORE: begin
        if (rx_mem_ack_i && !rx_last) begin
          rx_cnt_next = rx_cnt_reg + 14'h0001;
          rx_state_next = SPDMA_RX_WAIT;
        end else if (rx_mem_ack_i) begin
          rx_cnt_next = 14'h0000;
          if (rx_load_next[~rx_sel_reg]) begin
            rx_sel_next = ~rx_sel_reg;
            rx_state_next = SPDMA_RX_WAIT;
          end else if (rx_load_next[rx_sel_reg]) begin
            rx_state_next = SPDMA_RX_WAIT;
          end else begin
            rx_state_next = SPDMA_RX_IDLE;
          end
        end
      end
      default: rx_state_next = SPDMA_RX_IDLE;
    endcase
    if (rx_rst) begin
      rx_state_next = SPDMA_RX_IDLE;
      rx_cnt_next = 14'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_reg <= SPDMA_RX_IDLE;
      rx_sel_reg <= 1'b0;
      rx_cnt_reg <= 14'h0000;
      rx_load_reg <= 2'b00;
      rx_byte_reg <= 8'h00;
      frm_reg <= 2'b00;
      par_reg <= 2'b00;
      ovr_reg <= 2'b00;
      ovr_pend_reg <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_sel_reg <= rx_sel_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_load_reg <= rx_load_next;
      frm_reg <= frm_next;
      par_reg <= par_next;
      ovr_reg <= ovr_next;
      ovr_pend_reg <= ovr_pend_next;
      if (rx_take) begin
        rx_byte_reg <= rx_fifo_data_i;
      end
    end
  end
  assign rx_fifo_ready_o = rx_state_reg == SPDMA_RX_WAIT;
  assign rx_mem_req_o = rx_state_reg == SPDMA_RX_STORE;
  assign rx_mem_addr_o = rx_addr;
  assign rx_mem_data_o = rx_byte_reg;

  // slave select release: pin is synchronised before edge detection
  logic ss_meta_reg;
  logic ss_sync_reg;
  logic ss_prev_reg;
  logic [2:0] ssel_reg;
  logic [13:0] saved_cnt_reg;
  wire ss_release = ss_sync_reg & ~ss_prev_reg;
  wire ss_save = ss_release & spi_slave_mode_i &
    (rx_state_reg != SPDMA_RX_IDLE);
  wire [2:0] ssel_next = rx_rst ? `SPDMA_SSEL_NONE :
    ss_save ? {((ssel_reg == `SPDMA_SSEL_NONE) ? `SPDMA_SSEL_ONCE :
    `SPDMA_SSEL_MULTI), rx_sel_reg} :
    (|rx_set) ? `SPDMA_SSEL_NONE : ssel_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_meta_reg <= 1'b1;
      ss_sync_reg <= 1'b1;
      ss_prev_reg <= 1'b1;
      ssel_reg <= `SPDMA_SSEL_NONE;
      saved_cnt_reg <= 14'h0000;
    end else begin
      ss_meta_reg <= slave_select_n_i;
      ss_sync_reg <= ss_meta_reg;
      ss_prev_reg <= ss_sync_reg;
      ssel_reg <= ssel_next;
      if (ss_save) begin
        saved_cnt_reg <= rx_cnt_reg;
      end
    end
  end

  // read decode; unmapped offsets answer zero
  wire [31:0] stat_word = {19'h0, ssel_reg, frm_reg, par_reg, ovr_reg,
    tx_active, rx_active};
  wire [31:0] ctrl_word = {28'h0, tx_load_reg, rx_load_reg};
  always_comb begin
    case (wb_adr_i)
      `SPDMA_OFF_TX_BEG_A: rd_mux = `SPDMA_ADDR_BASE | {18'h0, g_buf[0].tx_beg_reg};
      `SPDMA_OFF_TX_BEG_B: rd_mux = `SPDMA_ADDR_BASE | {18'h0, g_buf[1].tx_beg_reg};
      `SPDMA_OFF_TX_END_A: rd_mux = `SPDMA_ADDR_BASE | {18'h0, g_buf[0].tx_end_reg};
      `SPDMA_OFF_TX_END_B: rd_mux = `SPDMA_ADDR_BASE | {18'h0, g_buf[1].tx_end_reg};
      `SPDMA_OFF_RX_BEG_A: rd_mux = `SPDMA_ADDR_BASE | {18'h0, g_buf[0].rx_beg_reg};
      `SPDMA_OFF_RX_BEG_B: rd_mux = `SPDMA_ADDR_BASE | {18'h0, g_buf[1].rx_beg_reg};
      `SPDMA_OFF_RX_END_A: rd_mux = `SPDMA_ADDR_BASE | {18'h0, g_buf[0].rx_end_reg};
      `SPDMA_OFF_RX_END_B: rd_mux = `SPDMA_ADDR_BASE | {18'h0, g_buf[1].rx_end_reg};
      `SPDMA_OFF_TX_CNT: rd_mux = {18'h0, tx_cnt_reg};
      `SPDMA_OFF_STAT: rd_mux = stat_word;
      `SPDMA_OFF_CTRL: rd_mux = ctrl_word;
      `SPDMA_OFF_SAVED: rd_mux = {18'h0, saved_cnt_reg};
      default: rd_mux = `SPDMA_REG_RST;
    endcase
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_tx_fetch_ok;
    tx_state_reg == SPDMA_TX_FETCH && tx_mem_ack_i && !tx_rst;
  endsequence
  sequence s_tx_pushed;
    tx_fifo_valid_o && tx_fifo_data_o == $past(tx_mem_data_i);
  endsequence

  a_tx_reset_idle:
    assert property (tx_rst |=> tx_state_reg == SPDMA_TX_IDLE &&
      tx_load_reg == 2'b00 && tx_cnt_reg == 14'h0000 && ctrl_word[3:2] == 2'b00)
    else $error("transmit reset did not idle the direction");
  a_rx_reset_idle:
    assert property (rx_rst |=> rx_state_reg == SPDMA_RX_IDLE &&
      rx_load_reg == 2'b00 && ssel_reg == `SPDMA_SSEL_NONE && ovr_reg == 2'b00)
    else $error("receive reset did not idle the direction");
  a_tx_load_arm:
    assert property (tx_set[0] |=> tx_load_reg[0] ##1
      tx_state_reg == SPDMA_TX_FETCH || tx_active != 2'b00)
    else $error("transmit load did not arm the buffer");
  a_rx_load_arm:
    assert property (rx_set[1] |=> rx_load_reg[1] &&
      g_buf[1].rx_lbeg_reg == $past(g_buf[1].rx_beg_reg))
    else $error("receive load did not latch buffer addresses");
  a_a_first:
    assert property (tx_state_reg == SPDMA_TX_IDLE && tx_load_reg == 2'b11 &&
      !tx_rst |=> tx_active == 2'b01)
    else $error("buffer A not served first");
  a_done_clears_load:
    assert property (tx_done && !tx_set[tx_sel_reg] && !tx_rst |=>
      !tx_load_reg[$past(tx_sel_reg)])
    else $error("load bit not cleared at completion");
  a_ssel_save_code:
    assert property (ss_save && ssel_reg == `SPDMA_SSEL_NONE && !rx_rst |=>
      ssel_reg == {`SPDMA_SSEL_ONCE, $past(rx_sel_reg)})
    else $error("saved status code wrong after first release");
  a_ssel_no_reserved:
    assert property (ssel_reg != 3'h1 && ssel_reg != 3'h4 && ssel_reg != 3'h5)
    else $error("saved status shows a reserved code");
  a_overrun_passed:
    assert property (rx_take && ovr_pend_reg && !rx_rst |=>
      ovr_reg[$past(rx_sel_reg)] && !ovr_pend_reg)
    else $error("pending overrun not passed to draining buffer");
  a_tx_byte_flow:
    assert property (s_tx_fetch_ok |=> s_tx_pushed)
    else $error("fetched byte not offered to transmit fifo");
  a_tx_count_load:
    assert property (tx_state_reg == SPDMA_TX_IDLE && |tx_load_reg && !tx_rst
      |=> tx_cnt_reg == 14'h0000 && tx_mem_req_o)
    else $error("transmit count not zero at buffer start");
  a_bus_ack_pulse:
    assert property (bus_req && !ack_reg |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle pulse");
endmodule
`default_nettype wire

// >>> testbench/spdma_far_model.sv
// far-side model: ram and serial fifos around the dma channel
`timescale 1ns/100ps
`default_nettype none
module spdma_far_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic rx_en_i,
  input wire logic frame_i,
  input wire logic parity_i,
  input wire logic tx_req_i,
  input wire logic [13:0] tx_addr_i,
  output logic tx_ack_o,
  output logic [7:0] tx_dat_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [7:0] rx_dat_o,
  output logic rx_frame_o,
  output logic rx_parity_o,
  input wire logic rx_req_i,
  output logic rx_ack_o,
  output logic [15:0] tx_n_o,
  output logic [7:0] tx_first_o,
  output logic [15:0] rx_n_o
);
  logic [1:0] wait_reg;
  logic tog_reg;
  // error flags only qualify a byte actually on offer
  assign rx_valid_o = rx_en_i;
  assign rx_frame_o = rx_en_i & frame_i;
  assign rx_parity_o = rx_en_i & parity_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_reg <= 2'h2;
      tog_reg <= 1'b0;
      tx_ack_o <= 1'b0;
      tx_dat_o <= 8'h00;
      tx_ready_o <= 1'b0;
      rx_ack_o <= 1'b0;
      rx_dat_o <= 8'h00;
      tx_n_o <= 16'h0000;
      tx_first_o <= 8'h00;
      rx_n_o <= 16'h0000;
    end else begin
      tog_reg <= ~tog_reg;
      tx_ack_o <= 1'b0;
      // read data is only valid in the ack cycle, so scramble it otherwise
      tx_dat_o <= ~tx_dat_o;
      if (tx_req_i && !tx_ack_o) begin
        if (wait_reg == 2'h0 || !slow_i) begin
          tx_ack_o <= 1'b1;
          tx_dat_o <= tx_addr_i[7:0] ^ 8'h5A;
          wait_reg <= 2'h2;
        end else begin
          wait_reg <= wait_reg - 2'h1;
        end
      end
      tx_ready_o <= !slow_i || tog_reg;
      if (tx_valid_i && tx_ready_o) begin
        tx_n_o <= tx_n_o + 16'h0001;
        if (tx_n_o == 16'h0000) begin
          tx_first_o <= tx_byte_i;
        end
      end
      if (!rx_valid_o || rx_ready_i) begin
        rx_dat_o <= rx_dat_o + 8'h01;
      end
      rx_ack_o <= rx_req_i && !rx_ack_o && (!slow_i || tog_reg);
      if (rx_ack_o) begin
        rx_n_o <= rx_n_o + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/spdma_top_test.sv
// self-checking bench for the serial ping-pong dma channel
`timescale 1ns/100ps
`include "spdma_map.svh"
`default_nettype none
module spdma_top_test;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, slow, rx_en;
  logic frame, parity, uart, spi, ssel_n, ovf, tx_req, tx_ack;
  logic tx_valid, tx_ready, rx_valid, rx_ready, rx_fe, rx_pe;
  logic rx_req, rx_ack;
  logic [15:0] wb_adr, tx_n, rx_n;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic [13:0] tx_addr, rx_addr;
  logic [7:0] tx_mdat, tx_fdat, rx_dat, rx_mdat, tx_first;
  logic [13:0] st_addr;
  logic [7:0] st_dat, tk_dat;
  int err_total, num_checks;
  // last byte taken from the fifo and last byte written to ram
  always @(posedge clk_i) begin
    if (rx_valid && rx_ready) begin
      tk_dat <= rx_dat;
    end
    if (rx_req && rx_ack) begin
      st_addr <= rx_addr;
      st_dat <= rx_mdat;
    end
  end
  spdma_top i_spdma_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .tx_mem_req_o(tx_req), .tx_mem_addr_o(tx_addr), .tx_mem_ack_i(tx_ack),
    .tx_mem_data_i(tx_mdat), .tx_fifo_valid_o(tx_valid),
    .tx_fifo_ready_i(tx_ready), .tx_fifo_data_o(tx_fdat),
    .rx_fifo_valid_i(rx_valid), .rx_fifo_ready_o(rx_ready),
    .rx_fifo_data_i(rx_dat), .rx_fifo_frame_err_i(rx_fe),
    .rx_fifo_parity_err_i(rx_pe), .rx_fifo_overflow_i(ovf),
    .uart_mode_i(uart), .spi_slave_mode_i(spi), .slave_select_n_i(ssel_n),
    .rx_mem_req_o(rx_req), .rx_mem_addr_o(rx_addr),
    .rx_mem_data_o(rx_mdat), .rx_mem_ack_i(rx_ack));
  spdma_far_model i_spdma_far_model (.clk_i(clk_i), .rst_i(rst_i),
    .slow_i(slow), .rx_en_i(rx_en), .frame_i(frame), .parity_i(parity),
    .tx_req_i(tx_req), .tx_addr_i(tx_addr), .tx_ack_o(tx_ack),
    .tx_dat_o(tx_mdat), .tx_valid_i(tx_valid), .tx_byte_i(tx_fdat),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .rx_dat_o(rx_dat), .rx_frame_o(rx_fe), .rx_parity_o(rx_pe),
    .rx_req_i(rx_req), .rx_ack_o(rx_ack), .tx_n_o(tx_n),
    .tx_first_o(tx_first), .rx_n_o(rx_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input logic [15:0] a,
      input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    n = 0;
    @(posedge clk_i);
    while (wb_ack !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 50) err_total++;
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // poll the control register until the given load bits drop
  task automatic idle(input logic [31:0] m);
    int n;
    n = 0;
    q = m;
    while ((q & m) !== 32'h0 && n < 500) begin
      bus(1'b0, `SPDMA_OFF_CTRL, 32'h0000_0000);
      n++;
    end
    if ((q & m) !== 32'h0) err_total++;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    results();
  end
  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = {1'b1, 51'h0};
    {slow, rx_en, frame, parity, uart, spi, ssel_n, ovf} = 8'h00;
    err_total = 0;
    num_checks = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(`SPDMA_OFF_TX_BEG_A, 32'h2000_0000);
    rc(`SPDMA_OFF_TX_BEG_B, 32'h2000_0000);
    rc(`SPDMA_OFF_CTRL, 32'h0000_0000);
    wr(`SPDMA_OFF_TX_BEG_A, 32'hFFFF_3FFF);
    rc(`SPDMA_OFF_TX_BEG_A, 32'h2000_3FFF);
    wr(`SPDMA_OFF_STAT, 32'hFFFF_FFFF);
    rc(`SPDMA_OFF_STAT, 32'h0000_0000);
    rc(16'hC8F0, 32'h0000_0000);
    $display("test registers done");
    slow <= 1'b1;
    wr(`SPDMA_OFF_TX_BEG_A, 32'h0000_0010);
    wr(`SPDMA_OFF_TX_END_A, 32'h0000_0013);
    wr(`SPDMA_OFF_TX_BEG_B, 32'h0000_0020);
    rc(`SPDMA_OFF_TX_BEG_B, 32'h2000_0020);
    wr(`SPDMA_OFF_TX_END_B, 32'h0000_0021);
    wr(`SPDMA_OFF_CTRL, 32'h0000_000C);
    wr(`SPDMA_OFF_CTRL, 32'h0000_0000);
    rc(`SPDMA_OFF_CTRL, 32'h0000_000C);
    rc(`SPDMA_OFF_STAT, 32'h0000_0004);
    idle(32'h0000_000C);
    rc(`SPDMA_OFF_CTRL, 32'h0000_0000);
    chk({16'h0, tx_n}, 32'h0000_0006);
    chk({24'h0, tx_first}, 32'h0000_004A);
    wr(`SPDMA_OFF_TX_BEG_A, 32'h0000_0000);
    wr(`SPDMA_OFF_TX_END_A, 32'h0000_3FFF);
    wr(`SPDMA_OFF_CTRL, 32'h0000_0004);
    wr(`SPDMA_OFF_CTRL, 32'h0000_0020);
    rc(`SPDMA_OFF_CTRL, 32'h0000_0000);
    rc(`SPDMA_OFF_STAT, 32'h0000_0000);
    rc(`SPDMA_OFF_TX_CNT, 32'h0000_0000);
    slow <= 1'b0;
    $display("test transmit done");
    uart <= 1'b1;
    frame <= 1'b1;
    wr(`SPDMA_OFF_RX_BEG_A, 32'h0000_0040);
    wr(`SPDMA_OFF_RX_END_A, 32'h0000_0043);
    wr(`SPDMA_OFF_CTRL, 32'h0000_0001);
    rc(`SPDMA_OFF_CTRL, 32'h0000_0001);
    rc(`SPDMA_OFF_STAT, 32'h0000_0001);
    rx_en <= 1'b1;
    idle(32'h0000_0001);
    rx_en <= 1'b0;
    rc(`SPDMA_OFF_STAT, 32'h0000_0100);
    chk({16'h0, rx_n}, 32'h0000_0004);
    chk({18'h0, st_addr}, 32'h0000_0043);
    chk({24'h0, st_dat}, {24'h0, tk_dat});
    frame <= 1'b0;
    parity <= 1'b1;
    wr(`SPDMA_OFF_CTRL, 32'h0000_0001);
    rc(`SPDMA_OFF_STAT, 32'h0000_0001);
    rx_en <= 1'b1;
    idle(32'h0000_0001);
    rx_en <= 1'b0;
    rc(`SPDMA_OFF_STAT, 32'h0000_0040);
    {parity, frame, uart} <= 3'b010;
    @(posedge clk_i);
    ovf <= 1'b1;
    @(posedge clk_i);
    ovf <= 1'b0;
    wr(`SPDMA_OFF_RX_BEG_B, 32'h0000_0050);
    wr(`SPDMA_OFF_RX_END_B, 32'h0000_0051);
    wr(`SPDMA_OFF_CTRL, 32'h0000_0002);
    rx_en <= 1'b1;
    idle(32'h0000_0002);
    rx_en <= 1'b0;
    rc(`SPDMA_OFF_STAT, 32'h0000_0060);
    wr(`SPDMA_OFF_CTRL, 32'h0000_0002);
    rc(`SPDMA_OFF_STAT, 32'h0000_0042);
    wr(`SPDMA_OFF_CTRL, 32'h0000_0010);
    rc(`SPDMA_OFF_STAT, 32'h0000_0000);
    rc(`SPDMA_OFF_CTRL, 32'h0000_0000);
    $display("test receive done");
    frame <= 1'b0;
    spi <= 1'b1;
    wr(`SPDMA_OFF_CTRL, 32'h0000_0001);
    // one byte lands first so the saved count is not zero
    repeat (2) @(posedge clk_i);
    rx_en <= 1'b1;
    @(posedge clk_i);
    rx_en <= 1'b0;
    ssel_n <= 1'b1;
    // the select pin passes a two-stage synchroniser first
    repeat (5) @(posedge clk_i);
    rc(`SPDMA_OFF_STAT, 32'h0000_0801);
    ssel_n <= 1'b0;
    repeat (5) @(posedge clk_i);
    ssel_n <= 1'b1;
    repeat (5) @(posedge clk_i);
    rc(`SPDMA_OFF_STAT, 32'h0000_1801);
    rc(`SPDMA_OFF_SAVED, 32'h0000_0001);
    chk({18'h0, st_addr}, 32'h0000_0040);
    wr(`SPDMA_OFF_CTRL, 32'h0000_0002);
    rc(`SPDMA_OFF_STAT, 32'h0000_0001);
    wr(`SPDMA_OFF_CTRL, 32'h0000_0010);
    rc(`SPDMA_OFF_STAT, 32'h0000_0000);
    $display("test saved count done");
    results();
  end
endmodule
`default_nettype wire
